/* rtl/session_keeper.sv */
/*
  Module end: parses session control frames from the host and keeps the
  client session and the table of incoming server sessions with timers.
  Assumes the radio side reports incoming requests and secure traffic.
*/
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
// What this block does
// - Timeout at offset 13, tenths, max 0x4650
// - Zero timeout means yielding, never expires
// - Full server evicts oldest yielding session
// - Never evict a non-zero timeout session
// - Password from offset 15, at most 64
// - Password ignored on logout or terminate
// - Checksum is 0xFF minus byte sum
// - Fixed timeout ends session regardless traffic
// - Inter-packet timeout restarts on secure traffic
// - Host drives unused option bits zero
// - Terminate addressed session, broadcast ends all
// - Frame type byte is 0x2E
// - Bit 0 selects client login or logout
// - Bit 1 ends incoming server sessions
// - Length counts bytes between length and checksum
`include "ssc_defines.svh"

module session_keeper
  import ssc_pkg::*;
#(
  parameter int MAX_IN = 4,
  parameter int TICK_CYCLES = `SSC_TICK_CYCLES
) (
  ssc_if.device link,
  input wire logic in_req,
  input wire logic [63:0] in_addr,
  input wire logic [15:0] in_timeout,
  input wire logic in_inter,
  input wire logic traffic,
  input wire logic [63:0] traffic_addr,
  output logic [MAX_IN-1:0] in_active,
  output logic in_refused,
  output logic client_active,
  output logic login_pulse,
  output logic logout_pulse,
  output logic frame_ok,
  output logic frame_bad
);
  logic clk;
  logic rst;
  parse_state_e state_reg;
  logic [15:0] len_reg;
  logic [15:0] pos_reg;
  logic [7:0] sum_reg;
  logic [7:0] type_reg;
  logic [63:0] addr_reg;
  logic [7:0] opts_reg;
  logic [15:0] tmo_reg;
  logic ready_reg;
  logic good;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [15:0] seq_reg;
  logic term_reg;
  logic [63:0] term_addr_reg;
  session_s sess_reg [MAX_IN];
  logic [MAX_IN-1:0] alloc;
  logic cl_inter_reg;
  logic [63:0] cl_addr_reg;
  logic [15:0] cl_tmo_reg;
  logic [15:0] cl_left_reg;

  function automatic logic hits(input logic [63:0] want, input logic [63:0] have);
    hits = want == `SSC_BCAST_ADDR || want == have;
  endfunction

  assign clk = link.clk;
  assign rst = link.rst;
  assign link.ready = ready_reg;

  // =====================================================================
  // Frame parser
  assign good = (sum_reg + link.data) == `SSC_CSUM_BASE
    && type_reg == `SSC_TYPE_CODE
    && len_reg >= `SSC_LEN_MIN && len_reg <= `SSC_LEN_MIN + 16'(`SSC_PW_MAX)
    && (opts_reg[`SSC_OPT_LOGOUT] || opts_reg[`SSC_OPT_TERM] || tmo_reg <= `SSC_TMO_MAX);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= P_IDLE;
      len_reg <= 16'h0000;
      pos_reg <= 16'h0000;
      sum_reg <= 8'h00;
      type_reg <= 8'h00;
      addr_reg <= 64'h0000_0000_0000_0000;
      opts_reg <= 8'h00;
      tmo_reg <= 16'h0000;
      ready_reg <= 1'b0;
      frame_ok <= 1'b0;
      frame_bad <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
      frame_ok <= 1'b0;
      frame_bad <= 1'b0;
      if (link.valid && ready_reg) begin
        case (state_reg)
          P_IDLE: begin
            if (link.data == `SSC_START_BYTE) begin
              state_reg <= P_LEN_HI;
            end
          end
          P_LEN_HI: begin
            len_reg[15:8] <= link.data;
            state_reg <= P_LEN_LO;
          end
          P_LEN_LO: begin
            len_reg[7:0] <= link.data;
            pos_reg <= `SSC_POS_TYPE;
            sum_reg <= 8'h00;
            state_reg <= ({len_reg[15:8], link.data} == 16'h0000) ? P_CSUM : P_BODY;
          end
          P_BODY: begin
            sum_reg <= sum_reg + link.data;
            pos_reg <= pos_reg + 16'h0001;
            if (pos_reg == `SSC_POS_TYPE) begin
              type_reg <= link.data;
            end else if (pos_reg < `SSC_POS_OPTS) begin
              addr_reg <= {addr_reg[55:0], link.data};
            end else if (pos_reg == `SSC_POS_OPTS) begin
              opts_reg <= link.data;
            end else if (pos_reg == `SSC_POS_TMO_HI) begin
              tmo_reg[15:8] <= link.data;
            end else if (pos_reg == `SSC_POS_TMO_LO) begin
              tmo_reg[7:0] <= link.data;
            end
            // Password bytes only enter the checksum; never kept
            if (pos_reg == len_reg + 16'h0002) begin
              state_reg <= P_CSUM;
            end
          end
          P_CSUM: begin
            state_reg <= P_IDLE;
            frame_ok <= good;
            frame_bad <= !good;
          end
          default: state_reg <= P_IDLE;
        endcase
      end
    end
  end

  // =====================================================================
  // Tenth-second tick
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end
  end

  // =====================================================================
  // Client session
  always_ff @(posedge clk) begin
    if (rst) begin
      client_active <= 1'b0;
      cl_inter_reg <= 1'b0;
      cl_addr_reg <= 64'h0000_0000_0000_0000;
      cl_tmo_reg <= 16'h0000;
      cl_left_reg <= 16'h0000;
      login_pulse <= 1'b0;
      logout_pulse <= 1'b0;
      term_reg <= 1'b0;
      term_addr_reg <= 64'h0000_0000_0000_0000;
    end else begin
      login_pulse <= 1'b0;
      logout_pulse <= 1'b0;
      term_reg <= 1'b0;
      if (state_reg == P_CSUM && link.valid && good) begin
        if (opts_reg[`SSC_OPT_LOGOUT]) begin
          logout_pulse <= client_active;
          client_active <= 1'b0;
        end else if (opts_reg[`SSC_OPT_TERM]) begin
          term_reg <= 1'b1;
          term_addr_reg <= addr_reg;
        end else begin
          login_pulse <= 1'b1;
          client_active <= 1'b1;
          cl_addr_reg <= addr_reg;
          cl_tmo_reg <= tmo_reg;
          cl_left_reg <= tmo_reg;
          cl_inter_reg <= opts_reg[`SSC_OPT_INTER];
        end
      end else if (client_active && cl_tmo_reg != `SSC_TMO_YIELD) begin
        if (traffic && cl_inter_reg && traffic_addr == cl_addr_reg) begin
          cl_left_reg <= cl_tmo_reg;
        end else if (tick_reg) begin
          cl_left_reg <= cl_left_reg - 16'h0001;
          if (cl_left_reg <= 16'h0001) begin
            client_active <= 1'b0;
          end
        end
      end
    end
  end

  // =====================================================================
  // Incoming session slot choice
  always_comb begin
    logic found;
    logic [15:0] best;
    int pick;
    found = 1'b0;
    best = 16'hFFFF;
    pick = -1;
    alloc = '0;
    for (int i = 0; i < MAX_IN; i++) begin
      if (!found && !sess_reg[i].valid) begin
        found = 1'b1;
        pick = i;
      end
    end
    for (int i = 0; i < MAX_IN; i++) begin
      if (!found && sess_reg[i].tmo == `SSC_TMO_YIELD && sess_reg[i].seq <= best) begin
        best = sess_reg[i].seq;
        pick = i;
      end
    end
    if (in_req && pick >= 0) begin
      alloc[pick] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_reg <= 16'h0000;
      in_refused <= 1'b0;
    end else begin
      in_refused <= in_req && alloc == '0;
      if (in_req && alloc != '0) begin
        seq_reg <= seq_reg + 16'h0001;
      end
    end
  end

  // =====================================================================
  // Incoming session table
  for (genvar g = 0; g < MAX_IN; g++) begin : g_sess
    assign in_active[g] = sess_reg[g].valid;

    always_ff @(posedge clk) begin
      if (rst) begin
        sess_reg[g] <= '0;
      end else if (alloc[g]) begin
        sess_reg[g].valid <= 1'b1;
        sess_reg[g].inter <= in_inter;
        sess_reg[g].addr <= in_addr;
        sess_reg[g].tmo <= in_timeout;
        sess_reg[g].left <= in_timeout;
        sess_reg[g].seq <= seq_reg;
      end else if (sess_reg[g].valid && term_reg && hits(term_addr_reg, sess_reg[g].addr)) begin
        sess_reg[g].valid <= 1'b0;
      end else if (sess_reg[g].valid && sess_reg[g].tmo != `SSC_TMO_YIELD) begin
        if (traffic && sess_reg[g].inter && traffic_addr == sess_reg[g].addr) begin
          sess_reg[g].left <= sess_reg[g].tmo;
        end else if (tick_reg) begin
          sess_reg[g].left <= sess_reg[g].left - 16'h0001;
          if (sess_reg[g].left <= 16'h0001) begin
            sess_reg[g].valid <= 1'b0;
          end
        end
      end
    end
  end
endmodule

/* inc/ssc_defines.svh */
/*
  Frame layout, field codes and timing counts for the secure session
  control frame. Assumes a 25 MHz system clock shared by both ends.
*/
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// =====================================================================
// Frame layout
`define SSC_START_BYTE 8'h7E
`define SSC_TYPE_CODE 8'h2E
`define SSC_POS_TYPE 16'h0003
`define SSC_POS_ADDR 16'h0004
`define SSC_POS_OPTS 16'h000C
`define SSC_POS_TMO_HI 16'h000D
`define SSC_POS_TMO_LO 16'h000E
`define SSC_POS_PW 16'h000F
`define SSC_LEN_MIN 16'h000C
`define SSC_PW_MAX 7'h40
`define SSC_CSUM_BASE 8'hFF

// =====================================================================
// Fields and values
`define SSC_OPT_LOGOUT 0
`define SSC_OPT_TERM 1
`define SSC_OPT_INTER 2
`define SSC_OPT_USED 8'h07
`define SSC_TMO_MAX 16'h4650
`define SSC_TMO_YIELD 16'h0000
`define SSC_BCAST_ADDR 64'h0000_0000_0000_FFFF

// =====================================================================
// Timing
`define SSC_CLK_NS 40
`define SSC_TENTH_NS 100000000
`define SSC_TICK_CYCLES (`SSC_TENTH_NS / `SSC_CLK_NS)

// =====================================================================
// Controller registers (byte addresses)
`define SSC_REG_DEST_LO 8'h00
`define SSC_REG_DEST_HI 8'h04
`define SSC_REG_CTRL 8'h08
`define SSC_REG_PW_LEN 8'h0C
`define SSC_REG_PW_DATA 8'h10
`define SSC_REG_GO 8'h14
`define SSC_REG_STATUS 8'h18
`define SSC_REG_IRQ_STAT 8'h1C
`define SSC_REG_IRQ_MASK 8'h20
`define SSC_IRQ_DONE 0
`define SSC_IRQ_REJECT 1

`endif

/* inc/ssc_pkg.sv */
/*
  Types shared by both ends of the secure session control frame link.
  Assumes ssc_defines.svh for numeric constants.
*/
package ssc_pkg;
  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_LEN_HI = 3'b001,
    P_LEN_LO = 3'b010,
    P_BODY = 3'b011,
    P_CSUM = 3'b100
  } parse_state_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SEND = 2'b01,
    S_CSUM = 2'b10
  } send_state_e;

  typedef struct packed {
    logic valid;
    logic inter;
    logic [63:0] addr;
    logic [15:0] tmo;
    logic [15:0] left;
    logic [15:0] seq;
  } session_s;
endpackage

/* inc/ssc_if.sv */
/*
  Byte stream carrying API frames from the host controller to the
  module. Assumes both ends run on the same clock.
*/
interface ssc_if (
  input wire logic clk,
  input wire logic rst
);
  logic [7:0] data;
  logic valid;
  logic ready;

  modport host (
    input clk,
    input rst,
    output data,
    output valid,
    input ready
  );

  modport device (
    input clk,
    input rst,
    input data,
    input valid,
    output ready
  );
endinterface

/* rtl/frame_sender.sv */
/*
  Host controller end: builds one session control frame from registers
  written over AXI4-Lite and sends it on the byte stream.
  Assumes a single clock and one outstanding read and write.
*/
`include "ssc_defines.svh"

module frame_sender
  import ssc_pkg::*;
(
  ssc_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  logic clk;
  logic rst;
  logic [63:0] dest_reg;
  logic [7:0] opts_reg;
  logic [15:0] tmo_reg;
  logic [6:0] pw_len_reg;
  logic [6:0] pw_wr_reg;
  logic [7:0] pw_mem [64];
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_set;
  send_state_e state_reg;
  logic [15:0] pos_reg;
  logic [7:0] sum_reg;
  logic [7:0] byte_next;
  logic [15:0] len;
  logic [7:0] data_reg;
  logic valid_reg;
  logic wr_go;
  logic rd_go;
  logic go;

  assign clk = link.clk;
  assign rst = link.rst;
  assign link.data = data_reg;
  assign link.valid = valid_reg;
  assign len = `SSC_LEN_MIN + {9'h000, pw_len_reg};
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign go = s_axi_awready && s_axi_awaddr == `SSC_REG_GO && s_axi_wdata[0] && state_reg == S_IDLE;

  // =====================================================================
  // AXI4-Lite slave
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr > `SSC_REG_IRQ_MASK) ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= rd_go;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `SSC_REG_DEST_LO: s_axi_rdata <= dest_reg[31:0];
          `SSC_REG_DEST_HI: s_axi_rdata <= dest_reg[63:32];
          `SSC_REG_CTRL: s_axi_rdata <= {tmo_reg, 8'h00, opts_reg};
          `SSC_REG_PW_LEN: s_axi_rdata <= {25'h0000000, pw_len_reg};
          `SSC_REG_STATUS: s_axi_rdata <= {31'h0000_0000, state_reg != S_IDLE};
          `SSC_REG_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_stat_reg};
          `SSC_REG_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask_reg};
          `SSC_REG_PW_DATA, `SSC_REG_GO: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Frame setup registers
  always_ff @(posedge clk) begin
    if (rst) begin
      dest_reg <= 64'h0000_0000_0000_0000;
      opts_reg <= 8'h00;
      tmo_reg <= 16'h0000;
      pw_len_reg <= 7'h00;
      pw_wr_reg <= 7'h00;
      irq_mask_reg <= 2'h0;
    end else if (s_axi_awready) begin
      case (s_axi_awaddr)
        `SSC_REG_DEST_LO: dest_reg[31:0] <= s_axi_wdata;
        `SSC_REG_DEST_HI: dest_reg[63:32] <= s_axi_wdata;
        `SSC_REG_CTRL: begin
          opts_reg <= s_axi_wdata[7:0] & `SSC_OPT_USED;
          tmo_reg <= s_axi_wdata[31:16];
        end
        `SSC_REG_PW_LEN: begin
          pw_len_reg <= (s_axi_wdata[6:0] > `SSC_PW_MAX) ? `SSC_PW_MAX : s_axi_wdata[6:0];
          pw_wr_reg <= 7'h00;
        end
        `SSC_REG_PW_DATA: begin
          if (pw_wr_reg < `SSC_PW_MAX) begin
            pw_wr_reg <= pw_wr_reg + 7'h01;
          end
        end
        `SSC_REG_IRQ_MASK: irq_mask_reg <= s_axi_wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (s_axi_awready && s_axi_awaddr == `SSC_REG_PW_DATA && pw_wr_reg < `SSC_PW_MAX) begin
      pw_mem[pw_wr_reg[5:0]] <= s_axi_wdata[7:0];
    end
  end

  // =====================================================================
  // Interrupts: set wins over write-one-to-clear
  assign irq_set[`SSC_IRQ_DONE] = state_reg == S_CSUM && link.ready;
  assign irq_set[`SSC_IRQ_REJECT] = go && tmo_reg > `SSC_TMO_MAX && !opts_reg[`SSC_OPT_LOGOUT];

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (s_axi_awready && s_axi_awaddr == `SSC_REG_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~s_axi_wdata[1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // =====================================================================
  // Frame sender
  always_comb begin
    byte_next = 8'h00;
    if (pos_reg == 16'h0001) begin
      byte_next = len[15:8];
    end else if (pos_reg == 16'h0002) begin
      byte_next = len[7:0];
    end else if (pos_reg == `SSC_POS_TYPE) begin
      byte_next = `SSC_TYPE_CODE;
    end else if (pos_reg < `SSC_POS_OPTS) begin
      byte_next = dest_reg[8'(16'h003F - ((pos_reg - `SSC_POS_ADDR) << 3)) -: 8];
    end else if (pos_reg == `SSC_POS_OPTS) begin
      byte_next = opts_reg;
    end else if (pos_reg == `SSC_POS_TMO_HI) begin
      byte_next = tmo_reg[15:8];
    end else if (pos_reg == `SSC_POS_TMO_LO) begin
      byte_next = tmo_reg[7:0];
    end else begin
      byte_next = pw_mem[6'(pos_reg - `SSC_POS_PW)];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      pos_reg <= 16'h0000;
      sum_reg <= 8'h00;
      data_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (go && !irq_set[`SSC_IRQ_REJECT]) begin
            state_reg <= S_SEND;
            data_reg <= `SSC_START_BYTE;
            valid_reg <= 1'b1;
            pos_reg <= 16'h0001;
            sum_reg <= 8'h00;
          end
        end
        S_SEND: begin
          if (link.ready) begin
            if (pos_reg > 16'h0003) begin
              sum_reg <= sum_reg + data_reg;
            end
            if (pos_reg == len + 16'h0003) begin
              state_reg <= S_CSUM;
              data_reg <= `SSC_CSUM_BASE - (sum_reg + data_reg);
            end else begin
              data_reg <= byte_next;
              pos_reg <= pos_reg + 16'h0001;
            end
          end
        end
        S_CSUM: begin
          if (link.ready) begin
            state_reg <= S_IDLE;
            valid_reg <= 1'b0;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

/* test/ssc_stream_properties.sv */
/*
  Checker for the byte stream between the host end and the module end.
  Assumes it sees the stream signals directly, on the one shared clock.
*/
`include "ssc_defines.svh"

module ssc_stream_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] data,
  input wire logic valid,
  input wire logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Frame position tracking
  logic [6:0] idx_reg;
  logic [15:0] len_reg;
  logic [7:0] sum_reg, opt_reg, hi_reg;
  logic take, last;

  assign take = valid && ready;
  assign last = take && idx_reg >= 7'h03 && {9'h000, idx_reg} == len_reg + 16'h0003;

  always_ff @(posedge clk) begin
    if (rst) begin
      idx_reg <= 7'h00;
    end else if (take) begin
      idx_reg <= last ? 7'h00 : idx_reg + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (take && idx_reg == 7'h01) len_reg[15:8] <= data;
    if (take && idx_reg == 7'h02) len_reg[7:0] <= data;
    if (take && idx_reg == 7'h0C) opt_reg <= data;
    if (take && idx_reg == 7'h0D) hi_reg <= data;
    if (take) sum_reg <= (idx_reg < 7'h03) ? 8'h00 : sum_reg + data;
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_start_byte: assert property ($rose(valid) |-> data == `SSC_START_BYTE)
    else $error("frame lacks the start byte");
  a_type_code: assert property (take && idx_reg == 7'h03 |-> data == `SSC_TYPE_CODE)
    else $error("wrong frame type byte");
  a_len_range: assert property (take && idx_reg == 7'h03 |-> len_reg >= 16'h000C && len_reg <= 16'h004C)
    else $error("frame length out of range");
  a_opts_clean: assert property (take && idx_reg == 7'h0C |-> (data & 8'hF8) == 8'h00)
    else $error("unused option bits set");
  a_tmo_max: assert property (take && idx_reg == 7'h0E && !opt_reg[0] |-> {hi_reg, data} <= `SSC_TMO_MAX)
    else $error("timeout above the limit sent");
  a_csum_ok: assert property (last |-> data == 8'hFF - sum_reg)
    else $error("checksum byte wrong");
  a_frame_close: assert property (last |=> !valid [*2])
    else $error("stream not idle after checksum");
  a_ready_up: assert property ($fell(rst) |=> ready)
    else $error("ready low after reset");

  c_logout: cover property (take && idx_reg == 7'h0C && data[0]);
  c_term: cover property (take && idx_reg == 7'h0C && data[1]);
  c_frame: cover property (last);
endmodule

/* test/secure_session_control_frame_test.sv */
/*
  Self-checking bench joining the host end and the module end.
  Assumes package, interface and design files are compiled first.
*/
`include "ssc_defines.svh"

module secure_session_control_frame_test
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic in_req = 1'b0, in_inter = 1'b0, traffic = 1'b0;
  logic [63:0] in_addr = 64'h0, traffic_addr = 64'h0;
  logic [15:0] in_timeout = 16'h0;
  logic [3:0] in_active;
  logic in_refused, client_active, login_pulse, logout_pulse, frame_ok, frame_bad;
  int error_cnt = 0, compares = 0, n_ok = 0, n_bad = 0, n_in = 0, n_out = 0, n_ref = 0;

  ssc_if link (.clk(clk), .rst(rst));
  frame_sender u_frame_sender (.link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  session_keeper #(.MAX_IN(4), .TICK_CYCLES(8)) u_session_keeper (.link(link), .in_req(in_req),
    .in_addr(in_addr), .in_timeout(in_timeout), .in_inter(in_inter), .traffic(traffic),
    .traffic_addr(traffic_addr), .in_active(in_active), .in_refused(in_refused),
    .client_active(client_active), .login_pulse(login_pulse), .logout_pulse(logout_pulse),
    .frame_ok(frame_ok), .frame_bad(frame_bad));
  ssc_stream_properties u_ssc_stream_properties (.clk(clk), .rst(rst), .data(link.data),
    .valid(link.valid), .ready(link.ready));

  // ==========================================================
  // Pulse counting and common tasks
  always @(posedge clk) begin
    if (!rst) begin
      n_ok <= n_ok + int'(frame_ok);
      n_bad <= n_bad + int'(frame_bad);
      n_in <= n_in + int'(login_pulse);
      n_out <= n_out + int'(logout_pulse);
      n_ref <= n_ref + int'(in_refused);
    end
  end

  task finish_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task guard(input int n);
    if (n > 300) begin
      error_cnt++;
      $display("CHECK FAILED %0t wait ran out", $time);
      finish_test;
    end
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic at, wt, bt;
    n = 0;
    bt = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bt) begin
      @(negedge clk);
      at = awready;
      wt = wready;
      bt = bvalid;
      r = bresp;
      @(posedge clk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) bready <= 1'b0;
      n++;
      guard(n);
    end
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic at, rt;
    n = 0;
    rt = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rt) begin
      @(negedge clk);
      at = arready;
      rt = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (at) arvalid <= 1'b0;
      if (rt) rready <= 1'b0;
      n++;
      guard(n);
    end
  endtask

  // Builds a frame through the registers and waits for the verdict
  task send(input logic [63:0] dst, input logic [7:0] opt, input logic [15:0] tmo, input int pw,
            input logic fr);
    logic [1:0] r;
    int n0, k;
    n0 = n_ok + n_bad;
    axi_wr(`SSC_REG_DEST_LO, dst[31:0], r);
    axi_wr(`SSC_REG_DEST_HI, dst[63:32], r);
    axi_wr(`SSC_REG_CTRL, {tmo, 8'h00, opt}, r);
    axi_wr(`SSC_REG_PW_LEN, 32'(pw), r);
    for (k = 0; k < pw; k++) axi_wr(`SSC_REG_PW_DATA, 32'h41 + 32'(k % 26), r);
    axi_wr(`SSC_REG_GO, 32'h1, r);
    k = 0;
    while (fr && n_ok + n_bad == n0) begin
      @(negedge clk);
      k++;
      guard(k);
    end
    repeat (2) @(negedge clk);
  endtask

  task req(input logic [63:0] a, input logic [15:0] t, input logic i);
    @(posedge clk);
    in_req <= 1'b1;
    in_addr <= a;
    in_timeout <= t;
    in_inter <= i;
    @(posedge clk);
    in_req <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task traf(input logic [63:0] a);
    @(posedge clk);
    traffic <= 1'b1;
    traffic_addr <= a;
    @(posedge clk);
    traffic <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task wait_irq(input logic lvl);
    int k;
    k = 0;
    while (irq !== lvl) begin
      @(negedge clk);
      k++;
      guard(k);
    end
  endtask

  // ==========================================================
  // Scenarios
  task s_login;
    int ok0, in0;
    ok0 = n_ok;
    in0 = n_in;
    send(64'h0000_1111_2222_3333, 8'h00, `SSC_TMO_MAX, 64, 1'b1);
    check(n_ok - ok0, 32'h1);
    check(n_in - in0, 32'h1);
    check(client_active, 32'h1);
  endtask

  task s_logout;
    int ok0, out0;
    ok0 = n_ok;
    out0 = n_out;
    send(64'h0000_1111_2222_3333, 8'h01, 16'hFFFF, 3, 1'b1);
    check(n_ok - ok0, 32'h1);
    check(n_out - out0, 32'h1);
    check(client_active, 32'h0);
  endtask

  task s_irq;
    logic [31:0] d;
    logic [1:0] r;
    int ok0;
    axi_rd(8'h24, d, r);
    check(r, 32'h2);
    axi_wr(`SSC_REG_IRQ_STAT, 32'h3, r);
    ok0 = n_ok + n_bad;
    send(64'h0000_1111_2222_3333, 8'h04, 16'h4651, 1, 1'b0);
    check(irq, 32'h0);
    axi_rd(`SSC_REG_IRQ_STAT, d, r);
    check(d, 32'h2);
    check(n_ok + n_bad - ok0, 32'h0);
    axi_wr(`SSC_REG_IRQ_MASK, 32'h2, r);
    wait_irq(1'b1);
    axi_wr(`SSC_REG_IRQ_STAT, 32'h2, r);
    wait_irq(1'b0);
  endtask

  task s_timers;
    int k;
    req(64'h0A, 16'h0003, 1'b0);
    req(64'h0B, 16'h0003, 1'b1);
    req(64'h0D, 16'h0000, 1'b0);
    for (k = 0; k < 12; k++) traf(k[0] ? 64'h0A : 64'h0B);
    check($countones(in_active), 32'h2);
    k = 0;
    while ($countones(in_active) != 1) begin
      @(negedge clk);
      k++;
      guard(k);
    end
    repeat (60) @(negedge clk);
    check($countones(in_active), 32'h1);
  endtask

  task s_evict;
    int r0;
    req(64'hC1, 16'h0100, 1'b0);
    req(64'hC2, 16'h0100, 1'b0);
    req(64'hC3, 16'h0100, 1'b0);
    r0 = n_ref;
    req(64'hC4, 16'h0100, 1'b0);
    check(n_ref - r0, 32'h0);
    check($countones(in_active), 32'h4);
    req(64'hC5, 16'h0100, 1'b0);
    check(n_ref - r0, 32'h1);
  endtask

  task s_term;
    int in0;
    in0 = n_in;
    send(64'hC2, 8'h02, 16'h0000, 2, 1'b1);
    check($countones(in_active), 32'h3);
    check(n_in - in0, 32'h0);
    send(`SSC_BCAST_ADDR, 8'h02, 16'h0000, 0, 1'b1);
    check($countones(in_active), 32'h0);
    check(n_bad, 32'h0);
  endtask

  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    s_login;
    s_logout;
    s_irq;
    s_timers;
    s_evict;
    s_term;
    finish_test;
  end
endmodule
